// >>> include/scb_pkg.sv
`default_nettype none
package scb_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_TXD  = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_CARD = 8'h10;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int CTL_TX_EMPTY_IRQ = 7;
  localparam int CTL_RX_IRQ       = 6;
  localparam int CTL_TX_ON        = 5;
  localparam int CTL_RX_ON        = 4;
  localparam int CTL_ADDR_FILT    = 3;
  localparam int CTL_TX_DONE_IRQ  = 2;
  localparam int CTL_CLK_SEL_HI   = 1;
  localparam int CTL_CLK_SEL_LO   = 0;

  // ************************************************************
  // Status register fields
  // ************************************************************
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL  = 6;
  localparam int ST_OVERRUN  = 5;
  localparam int ST_FRAMING  = 4;
  localparam int ST_PARITY   = 3;
  localparam int ST_TX_DONE  = 2;
  localparam int ST_MPB      = 1;
  localparam int ST_MPBT     = 0;

  // ************************************************************
  // Mode and card register fields
  // ************************************************************
  localparam int MOD_SYNC      = 7;
  localparam int MOD_CLK_STYLE = 6;
  localparam int MOD_ADDR_FRM  = 2;
  localparam int CARD_SEL      = 0;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h84;
  localparam logic [1:0] CKS_PORT = 2'h0;
  localparam logic [1:0] CKS_OUT  = 2'h1;
  localparam logic [1:0] CKS_HIGH = 2'h2;
  localparam int         OS_PER_BIT = 16;
  localparam int         APB_DW     = 32;

  typedef enum logic [2:0] {SCB_SCK_PORT, SCB_SCK_CLK, SCB_SCK_LOW, SCB_SCK_HIGH, SCB_SCK_EXT} scb_sck_role_t;

endpackage
`default_nettype wire

// >>> hw/scb_clk_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module scb_clk_ctl #(
  parameter int BAUD_DIV = 8
) (
  input  wire logic       clk,            // Core clock
  input  wire logic       rstn,           // Sync reset, low
  input  wire logic       sync_mode,      // Clocked synchronous mode
  input  wire logic       card_mode,      // Smart-card mode
  input  wire logic       card_clk_style, // Card pin style
  input  wire logic [1:0] clk_sel,        // Clock select field
  input  wire logic       sck_i,          // Clock pin level in
  output logic            sck_o,          // Clock pin level out
  output logic            sck_oe,         // Clock pin drive enable
  output logic            ext_clk,        // External clock in use
  output logic            os_tick,        // Oversample tick
  output logic            bit_tick        // Bit-rate tick
);

  // Divider counter is 16 bits wide
  if (BAUD_DIV < 1 || BAUD_DIV > 65536) $error("BAUD_DIV out of range for the divider");

  typedef struct packed {
    logic [15:0] div_cnt;
    logic [3:0]  os_cnt;
    logic        sck_q;
    logic        sck_out;
  } scb_clk_state_t;

  scb_clk_state_t st, next_st;
  scb_pkg::scb_sck_role_t role;
  logic int_tick;
  logic ext_edge;
  logic os_last;

  // ************************************************************
  // Pin role
  // ************************************************************
  always_comb
  begin
    if (card_mode && !card_clk_style)
      role = (clk_sel == scb_pkg::CKS_OUT) ? scb_pkg::SCB_SCK_CLK : scb_pkg::SCB_SCK_PORT;
    else if (card_mode)
    begin
      if (clk_sel[0])
        role = scb_pkg::SCB_SCK_CLK;
      else
        role = clk_sel[1] ? scb_pkg::SCB_SCK_HIGH : scb_pkg::SCB_SCK_LOW;
    end
    else if (clk_sel[1])
      role = scb_pkg::SCB_SCK_EXT;
    else if (sync_mode || clk_sel == scb_pkg::CKS_OUT)
      role = scb_pkg::SCB_SCK_CLK;
    else
      role = scb_pkg::SCB_SCK_PORT;
  end

  assign ext_clk  = (role == scb_pkg::SCB_SCK_EXT);
  assign int_tick = (st.div_cnt == 16'(BAUD_DIV - 1));
  assign ext_edge = sck_i && !st.sck_q;
  assign os_last  = (st.os_cnt == 4'(scb_pkg::OS_PER_BIT - 1));
  assign os_tick  = ext_clk ? ext_edge : int_tick;
  // In sync mode an outside clock edge is itself the bit clock
  assign bit_tick = (ext_clk && sync_mode) ? ext_edge : (os_tick && os_last);
  assign sck_oe   = (role != scb_pkg::SCB_SCK_PORT) && (role != scb_pkg::SCB_SCK_EXT);
  assign sck_o    = st.sck_out;

  always_comb
  begin
    next_st         = st;
    next_st.sck_q   = sck_i;
    next_st.div_cnt = int_tick ? 16'h0000 : st.div_cnt + 16'h0001;
    if (os_tick)
      next_st.os_cnt = os_last ? 4'h0 : st.os_cnt + 4'h1;
    case (role)
      scb_pkg::SCB_SCK_CLK:  next_st.sck_out = next_st.os_cnt[3];
      scb_pkg::SCB_SCK_HIGH: next_st.sck_out = 1'b1;
      default:               next_st.sck_out = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

endmodule
`default_nettype wire

// >>> hw/scb_ctl.sv
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module scb_ctl #(
  parameter int APB_AW   = 8,
  parameter int BAUD_DIV = 8
) (
  input  wire logic              clk,         // Core clock
  input  wire logic              rstn,        // Sync reset, low
  input  wire logic [APB_AW-1:0] paddr,       // APB address
  input  wire logic              psel,        // APB select
  input  wire logic              penable,     // APB enable
  input  wire logic              pwrite,      // APB direction
  input  wire logic [31:0]       pwdata,      // APB write data
  output logic      [31:0]       prdata,      // APB read data
  output logic                   pready,      // APB ready
  output logic                   pslverr,     // APB error
  input  wire logic              tx_load_evt, // Holding byte moved to shifter
  input  wire logic              tx_end_evt,  // Last bit sent, nothing queued
  input  wire logic              rx_done_evt, // Received frame complete
  input  wire logic              rx_fer,      // Frame had framing error
  input  wire logic              rx_per,      // Frame had parity error
  input  wire logic              rx_mpb,      // Frame address bit
  input  wire logic              rxd,         // Serial data in
  input  wire logic              sck_i,       // Clock pin in
  output logic                   sck_o,       // Clock pin out
  output logic                   sck_oe,      // Clock pin drive enable
  output logic                   ext_clk,     // External clock selected
  output logic                   os_tick,     // Oversample tick
  output logic                   bit_tick,    // Bit tick
  output logic      [7:0]        tx_data,     // Byte to transmit
  output logic                   tx_mpbt,     // Address bit to transmit
  output logic                   tx_ready,    // Holding byte ready to send
  output logic                   rx_start,    // Reception start pulse
  output logic                   tx_empty_req, // Buffer-empty request
  output logic                   rx_full_req,  // Receive-full request
  output logic                   rx_error_req, // Receive-error request
  output logic                   tx_done_req   // Transmit-end request
);

  if (APB_AW < 5) $error("APB_AW too small for register map");

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  mode;
    logic        card_sel;
    logic [7:0]  txd;
    logic [7:0]  stat;
    logic [7:0]  armed;
    logic [31:0] rdata;
    logic        err;
    logic        rxd_q;
  } scb_ctl_state_t;

  scb_ctl_state_t st, next_st;
  logic [7:0] wadr;
  logic       setup;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       hit;
  logic       card;
  logic       filt_on;
  logic       rx_evt;
  logic       rx_take;
  logic [7:0] clr;

  // ************************************************************
  // APB slave, zero wait
  // ************************************************************
  assign wadr    = 8'(paddr);
  assign setup   = psel && !penable;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && !st.err;
  assign rd      = acc && !pwrite && !st.err;
  assign pready  = acc;
  assign pslverr = acc && st.err;
  assign prdata  = st.rdata;
  assign hit     = (wadr == scb_pkg::OFS_MODE) || (wadr == scb_pkg::OFS_CTRL) || (wadr == scb_pkg::OFS_TXD)
                || (wadr == scb_pkg::OFS_STAT) || (wadr == scb_pkg::OFS_CARD);

  // ************************************************************
  // Mode decode
  // ************************************************************
  assign card    = st.card_sel;
  // Filter bit is inert unless async address-frame mode
  assign filt_on = st.ctrl[scb_pkg::CTL_ADDR_FILT] && st.mode[scb_pkg::MOD_ADDR_FRM]
                && !st.mode[scb_pkg::MOD_SYNC] && !card;
  assign rx_evt  = rx_done_evt && st.ctrl[scb_pkg::CTL_RX_ON];
  assign rx_take = rx_evt && !(filt_on && !rx_mpb);

  // Write-zero clears only take effect on flags read as one; transmit-end clears along with the empty flag
  always_comb
  begin
    clr = 8'h00;
    if (wr && wadr == scb_pkg::OFS_STAT)
      clr = ~pwdata[7:0] & st.armed;
    clr[scb_pkg::ST_TX_DONE] = clr[scb_pkg::ST_TX_EMPTY];
    // Received address bit is read-only
    clr[scb_pkg::ST_MPB]     = 1'b0;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    next_st       = st;
    next_st.rxd_q = rxd;
    if (setup)
    begin
      next_st.err   = !hit;
      next_st.rdata = 32'h00000000;
      case (wadr)
        scb_pkg::OFS_MODE: next_st.rdata[7:0] = st.mode;
        scb_pkg::OFS_CTRL: next_st.rdata[7:0] = st.ctrl;
        scb_pkg::OFS_TXD:  next_st.rdata[7:0] = st.txd;
        scb_pkg::OFS_STAT: next_st.rdata[7:0] = st.stat;
        scb_pkg::OFS_CARD: next_st.rdata[scb_pkg::CARD_SEL] = st.card_sel;
        default:           next_st.rdata      = 32'h00000000;
      endcase
    end
    if (acc)
      next_st.err = 1'b0;
    if (wr)
    begin
      case (wadr)
        scb_pkg::OFS_MODE: next_st.mode     = pwdata[7:0];
        scb_pkg::OFS_CTRL: next_st.ctrl     = pwdata[7:0];
        scb_pkg::OFS_TXD:  next_st.txd      = pwdata[7:0];
        scb_pkg::OFS_CARD: next_st.card_sel = pwdata[scb_pkg::CARD_SEL];
        scb_pkg::OFS_STAT: next_st.stat[scb_pkg::ST_MPBT] = pwdata[scb_pkg::ST_MPBT];
        default:           next_st.err      = 1'b0;
      endcase
    end
    // Arm on a status read, disarm after any status write
    if (rd && wadr == scb_pkg::OFS_STAT)
      next_st.armed = st.armed | st.rdata[7:0];
    else if (wr && wadr == scb_pkg::OFS_STAT)
      next_st.armed = 8'h00;
    // Clears first so a same-cycle set wins
    next_st.stat = next_st.stat & ~clr;
    if (tx_load_evt)
      next_st.stat[scb_pkg::ST_TX_EMPTY] = 1'b1;
    if (tx_end_evt)
      next_st.stat[scb_pkg::ST_TX_DONE] = 1'b1;
    if (rx_take)
    begin
      if (st.stat[scb_pkg::ST_RX_FULL])
        next_st.stat[scb_pkg::ST_OVERRUN] = 1'b1;
      else
      begin
        next_st.stat[scb_pkg::ST_RX_FULL] = 1'b1;
        next_st.stat[scb_pkg::ST_FRAMING] = next_st.stat[scb_pkg::ST_FRAMING] | rx_fer;
        next_st.stat[scb_pkg::ST_PARITY]  = next_st.stat[scb_pkg::ST_PARITY] | rx_per;
      end
    end
    if (rx_evt && filt_on && rx_mpb)
    begin
      next_st.ctrl[scb_pkg::CTL_ADDR_FILT] = 1'b0;
      next_st.stat[scb_pkg::ST_MPB]        = 1'b1;
    end
    else if (rx_take)
      next_st.stat[scb_pkg::ST_MPB] = rx_mpb;
    // Transmitter off pins the empty flag high
    if (!next_st.ctrl[scb_pkg::CTL_TX_ON])
      next_st.stat[scb_pkg::ST_TX_EMPTY] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st      <= '0;
      st.ctrl <= scb_pkg::CTRL_RST;
      st.mode <= scb_pkg::MODE_RST;
      st.stat <= scb_pkg::STAT_RST;
    end
    else
      st <= next_st;
  end

  // ************************************************************
  // Requests and datapath hooks
  // ************************************************************
  assign tx_empty_req = st.ctrl[scb_pkg::CTL_TX_EMPTY_IRQ] && st.stat[scb_pkg::ST_TX_EMPTY];
  assign rx_full_req  = st.ctrl[scb_pkg::CTL_RX_IRQ] && st.stat[scb_pkg::ST_RX_FULL];
  assign rx_error_req = st.ctrl[scb_pkg::CTL_RX_IRQ]
                     && |{st.stat[scb_pkg::ST_FRAMING], st.stat[scb_pkg::ST_PARITY], st.stat[scb_pkg::ST_OVERRUN]};
  // Transmit-end has no card meaning, so it stays masked there
  assign tx_done_req  = st.ctrl[scb_pkg::CTL_TX_DONE_IRQ] && !card && st.stat[scb_pkg::ST_TX_DONE];
  assign tx_data      = st.txd;
  assign tx_mpbt      = st.stat[scb_pkg::ST_MPBT];
  assign tx_ready     = st.ctrl[scb_pkg::CTL_TX_ON] && !st.stat[scb_pkg::ST_TX_EMPTY];
  // Async waits for a falling start edge, sync for the shift clock
  assign rx_start     = st.ctrl[scb_pkg::CTL_RX_ON]
                     && (st.mode[scb_pkg::MOD_SYNC] ? bit_tick : (st.rxd_q && !rxd));

  scb_clk_ctl #(
    .BAUD_DIV (BAUD_DIV)
  ) u_clk (
    .clk            (clk),
    .rstn           (rstn),
    .sync_mode      (st.mode[scb_pkg::MOD_SYNC]),
    .card_mode      (card),
    .card_clk_style (st.mode[scb_pkg::MOD_CLK_STYLE]),
    .clk_sel        ({st.ctrl[scb_pkg::CTL_CLK_SEL_HI], st.ctrl[scb_pkg::CTL_CLK_SEL_LO]}),
    .sck_i          (sck_i),
    .sck_o          (sck_o),
    .sck_oe         (sck_oe),
    .ext_clk        (ext_clk),
    .os_tick        (os_tick),
    .bit_tick       (bit_tick)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  logic [1:0] cks;
  logic       sync_m;
  assign cks    = {st.ctrl[scb_pkg::CTL_CLK_SEL_HI], st.ctrl[scb_pkg::CTL_CLK_SEL_LO]};
  assign sync_m = st.mode[scb_pkg::MOD_SYNC];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rd_tx_buf_empty_one;
    rd && wadr == scb_pkg::OFS_STAT && st.rdata[scb_pkg::ST_TX_EMPTY] && st.ctrl[scb_pkg::CTL_TX_ON];
  endsequence
  sequence s_wr_tx_buf_empty_zero;
    wr && wadr == scb_pkg::OFS_STAT && !pwdata[scb_pkg::ST_TX_EMPTY] && !tx_load_evt && !tx_end_evt
      && st.ctrl[scb_pkg::CTL_TX_ON];
  endsequence

  AST_TX_DONE_FLAG_WITHDRAW: assert property (s_rd_tx_buf_empty_one ##[1:4] s_wr_tx_buf_empty_zero |=> !tx_done_req && !tx_empty_req)
    else $error("transmit requests not withdrawn after flag clear");
  AST_TEI_RAISE: assert property ($rose(st.stat[scb_pkg::ST_TX_DONE]) && st.ctrl[scb_pkg::CTL_TX_DONE_IRQ]
                                  && !card |-> tx_done_req)
    else $error("transmit-end request not raised");
  AST_TXI_MASK: assert property (!st.ctrl[scb_pkg::CTL_TX_EMPTY_IRQ] |-> !tx_empty_req)
    else $error("buffer-empty request leaked while masked");
  AST_RX_MASK: assert property (!st.ctrl[scb_pkg::CTL_RX_IRQ] |-> !rx_full_req && !rx_error_req)
    else $error("receive request leaked while masked");
  AST_TX_BUF_EMPTY_HELD: assert property (!st.ctrl[scb_pkg::CTL_TX_ON] ##1 !st.ctrl[scb_pkg::CTL_TX_ON]
                                  |-> st.stat[scb_pkg::ST_TX_EMPTY] && !tx_ready)
    else $error("empty flag not held while transmitter off");
  AST_RX_KEEP: assert property ($fell(st.ctrl[scb_pkg::CTL_RX_ON]) && !wr && !rx_done_evt
                                |=> $stable(st.stat[scb_pkg::ST_RX_FULL:scb_pkg::ST_PARITY]))
    else $error("receive flags changed when receiver stopped");
  AST_SCK_ASYNC_PORT: assert property (!card && !sync_m && cks == scb_pkg::CKS_PORT |-> !sck_oe && !ext_clk)
    else $error("clock pin not released");
  AST_SCK_EXT_IN: assert property (!card && cks[1] |-> !sck_oe && ext_clk)
    else $error("clock pin not an input");
  AST_SCK_SYNC_OUT: assert property (!card && sync_m && !cks[1] |-> sck_oe && !ext_clk)
    else $error("sync internal clock not driven");
  AST_CARD_HOLD: assert property (card && st.mode[scb_pkg::MOD_CLK_STYLE] && !cks[0]
                                  ##1 $stable(st.ctrl) |-> sck_oe && sck_o == cks[1])
    else $error("card clock pin level wrong");
  AST_FILTER_SKIP: assert property (filt_on && rx_done_evt && st.ctrl[scb_pkg::CTL_RX_ON] && !rx_mpb
                                    && !st.stat[scb_pkg::ST_RX_FULL] && !wr
                                    |=> !st.stat[scb_pkg::ST_RX_FULL])
    else $error("filtered frame set receive flag");
  AST_RX_START: assert property (!st.ctrl[scb_pkg::CTL_RX_ON] |-> !rx_start)
    else $error("reception started while disabled");

endmodule
`default_nettype wire

// >>> tb/scb_peer.sv
`timescale 1ns/1ns
`default_nettype none
module scb_peer #(
  parameter int HALF = 2
) (
  input  wire logic clk,        // Core clock
  input  wire logic run_clk,    // Supply a clock on the pin
  input  wire logic send_start, // Begin a start bit
  output var  logic rxd,        // Serial data towards the block
  output var  logic sck_i       // Clock pin level from far side
);
  int unsigned ph;
  int unsigned low_left;
  initial
  begin
    rxd = 1'b1;
    sck_i = 1'b0;
    ph = 0;
    low_left = 0;
  end
  // Pin clock stands low outside use; HALF sets the 16x rate
  always @(posedge clk)
  begin
    if (run_clk)
    begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1) sck_i <= ~sck_i;
    end
    else sck_i <= 1'b0;
    if (send_start) low_left <= 16;
    else if (low_left != 0) low_left <= low_left - 1;
    rxd <= !(send_start || low_left > 1);
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int DIV = 1;
  localparam logic [7:0] A_MD = scb_pkg::OFS_MODE, A_CT = scb_pkg::OFS_CTRL, A_TX = scb_pkg::OFS_TXD;
  localparam logic [7:0] A_ST = scb_pkg::OFS_STAT, A_CD = scb_pkg::OFS_CARD;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, r;
  logic tx_load_evt = 1'b0, tx_end_evt = 1'b0, rx_done_evt = 1'b0, rx_fer = 1'b0, rx_per = 1'b0;
  logic rx_mpb = 1'b0, run_clk = 1'b0, send_start = 1'b0, rxd, sck_i, last_sck = 1'b0, e;
  logic pready, pslverr, sck_o, sck_oe, ext_clk, os_tick, bit_tick, tx_mpbt, tx_ready, rx_start;
  logic tx_empty_req, rx_full_req, rx_error_req, tx_done_req;
  logic [7:0] tx_data;
  int fail_count = 0, n_tests = 0, cyc = 0, n_bit = 0, n_os = 0, n_sck = 0, n_rxs = 0, db, dos, dsck;
  scb_ctl #(.APB_AW(8), .BAUD_DIV(DIV)) u_scb_ctl (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_load_evt(tx_load_evt), .tx_end_evt(tx_end_evt), .rx_done_evt(rx_done_evt), .rx_fer(rx_fer),
    .rx_per(rx_per), .rx_mpb(rx_mpb), .rxd(rxd), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
    .ext_clk(ext_clk), .os_tick(os_tick), .bit_tick(bit_tick), .tx_data(tx_data), .tx_mpbt(tx_mpbt),
    .tx_ready(tx_ready), .rx_start(rx_start), .tx_empty_req(tx_empty_req), .rx_full_req(rx_full_req),
    .rx_error_req(rx_error_req), .tx_done_req(tx_done_req));
  scb_peer #(.HALF(2)) u_scb_peer (.clk(clk), .run_clk(run_clk), .send_start(send_start), .rxd(rxd),
    .sck_i(sck_i));
  initial
  begin
    forever #2 clk = ~clk;
  end
  // Tick counters plus the hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    last_sck <= sck_o;
    if (bit_tick === 1'b1) n_bit <= n_bit + 1;
    if (os_tick === 1'b1) n_os <= n_os + 1;
    if (rx_start === 1'b1) n_rxs <= n_rxs + 1;
    if (sck_o === 1'b1 && last_sck === 1'b0) n_sck <= n_sck + 1;
    if (cyc == 20000)
    begin
      fail_count = fail_count + 1;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      fail_count = fail_count + 1;
    end
  endtask
  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic x;
    apb(1'b1, a, d, q, x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic x;
    apb(1'b0, a, 8'h00, r, x);
    chk(r & mask, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    tx_load_evt <= (k == 0);
    tx_end_evt <= (k == 1);
    rx_done_evt <= (k == 2);
    @(posedge clk);
    tx_load_evt <= 1'b0;
    tx_end_evt <= 1'b0;
    rx_done_evt <= 1'b0;
    @(negedge clk);
  endtask
  // Counts over a whole number of periods so phase cannot matter
  task automatic span();
    int b0, o0, s0;
    // Let the pin register settle into the new role first
    repeat (3) @(negedge clk);
    b0 = n_bit;
    o0 = n_os;
    s0 = n_sck;
    repeat (64) @(negedge clk);
    db = n_bit - b0;
    dos = n_os - o0;
    dsck = n_sck - s0;
  endtask
  task automatic t_reset();
    rd(A_CT, 32'hffffffff, 32'h00000000);
    rd(A_ST, 32'hffffffff, 32'h00000084);
    wr(A_ST, 8'hff);
    rd(A_ST, 32'hffffffff, 32'h00000085);
    chk(tx_mpbt, 1'b1);
    wr(A_ST, 8'hfe);
    wr(A_CT, 8'hcb);
    rd(A_CT, 32'hffffffff, 32'h000000cb);
    wr(A_CT, 8'h00);
    apb(1'b0, 8'h3c, 8'h00, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_tx();
    wr(A_CT, 8'ha0);
    @(negedge clk);
    chk(tx_empty_req, 1'b1);
    wr(A_TX, 8'h5a);
    rd(A_ST, 32'hffffffff, 32'h00000084);
    wr(A_ST, 8'h00);
    @(negedge clk);
    chk(tx_empty_req, 1'b0);
    chk({tx_ready, tx_data}, 9'h15a);
    pulse(0);
    chk(tx_empty_req, 1'b1);
    wr(A_CT, 8'h24);
    @(negedge clk);
    chk({tx_empty_req, tx_done_req}, 2'b00);
    pulse(1);
    chk(tx_done_req, 1'b1);
    rd(A_ST, 32'h00000084, 32'h00000084);
    wr(A_ST, 8'h00);
    @(negedge clk);
    chk(tx_done_req, 1'b0);
    pulse(1);
    wr(A_CT, 8'h20);
    @(negedge clk);
    chk(tx_done_req, 1'b0);
    wr(A_CT, 8'h00);
    rd(A_ST, 32'h00000080, 32'h00000080);
    wr(A_ST, 8'h00);
    rd(A_ST, 32'h00000080, 32'h00000080);
    $display("test tx done");
  endtask
  task automatic t_rx();
    int rx0;
    wr(A_CT, 8'h50);
    rx_fer <= 1'b1;
    pulse(2);
    chk({rx_full_req, rx_error_req}, 2'b11);
    @(posedge clk);
    rx_fer <= 1'b0;
    wr(A_CT, 8'h40);
    pulse(2);
    rd(A_ST, 32'h00000078, 32'h00000050);
    wr(A_ST, 8'h00);
    @(negedge clk);
    chk({rx_full_req, rx_error_req}, 2'b00);
    wr(A_CT, 8'h50);
    pulse(2);
    wr(A_CT, 8'h10);
    @(negedge clk);
    chk(rx_full_req, 1'b0);
    rx0 = n_rxs;
    @(posedge clk);
    send_start <= 1'b1;
    @(posedge clk);
    send_start <= 1'b0;
    repeat (20) @(posedge clk);
    chk(n_rxs - rx0, 1);
    rd(A_ST, 32'h00000040, 32'h00000040);
    wr(A_ST, 8'h00);
    wr(A_MD, 8'h04);
    wr(A_CT, 8'h58);
    pulse(2);
    chk(rx_full_req, 1'b0);
    @(posedge clk);
    rx_mpb <= 1'b1;
    pulse(2);
    chk(rx_full_req, 1'b1);
    rd(A_CT, 32'h00000008, 32'h00000000);
    rx_mpb <= 1'b0;
    wr(A_CT, 8'h00);
    $display("test rx done");
  endtask
  task automatic t_clk();
    wr(A_MD, 8'h00);
    @(negedge clk);
    chk({sck_oe, ext_clk}, 2'b00);
    wr(A_CT, 8'h01);
    span();
    chk({sck_oe, ext_clk, db[7:0], dsck[7:0]}, {2'b10, 8'd4, 8'd4});
    @(posedge clk);
    run_clk <= 1'b1;
    wr(A_CT, 8'h02);
    span();
    chk({sck_oe, ext_clk, dos[7:0]}, {2'b01, 8'd16});
    wr(A_MD, 8'h80);
    wr(A_CT, 8'h00);
    span();
    chk({sck_oe, dsck[7:0]}, {1'b1, 8'd4});
    wr(A_CT, 8'h02);
    span();
    chk({sck_oe, ext_clk, db[7:0]}, {2'b01, 8'd16});
    @(posedge clk);
    run_clk <= 1'b0;
    wr(A_MD, 8'h40);
    wr(A_CT, 8'h00);
    wr(A_CD, 8'h01);
    repeat (2) @(negedge clk);
    chk({sck_oe, sck_o}, 2'b10);
    wr(A_CT, 8'h02);
    repeat (2) @(negedge clk);
    chk({sck_oe, sck_o}, 2'b11);
    wr(A_CT, 8'h03);
    span();
    chk({sck_oe, dsck[7:0]}, {1'b1, 8'd4});
    wr(A_MD, 8'h00);
    wr(A_CT, 8'h02);
    @(negedge clk);
    chk(sck_oe, 1'b0);
    $display("test clock done");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_clk();
    conclude();
  end
endmodule
`default_nettype wire
